// ==== core/channel_clock_measure.sv ====
// channel post-dividers and gated frequency measurement
module channel_clock_measure
  import clock_generator_pkg::*;
#(
  parameter int GATE_LEN = GATE_CYCLES
)(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // generator clocks, sampled
  input  wire logic [3:0]           gen_clk,
  // configuration
  input  wire logic [15:0]          div_cfg,
  input  wire logic                 start,
  input  wire logic [3:0]           sel,
  // results
  output logic      [3:0]           baud_src,
  output logic                      meas_done,
  output logic      [VALUE_W-1:0]   meas_value,
  output logic                      done_pulse
);

  localparam int GATE_W = $clog2(GATE_LEN + 1);

  if (GATE_LEN < 2)
    $error("gate length too short");

  typedef struct packed {
    logic [3:0]         prev;
    logic [3:0][14:0]   cnt;
    logic [3:0]         baud;
    logic [3:0]         bprev;
    logic [1:0]         ch;
    logic               done;
    logic [GATE_W-1:0]  gate;
    logic [VALUE_W-1:0] edges;
    logic [VALUE_W-1:0] value;
    logic               pulse;
  } meas_state_t;

  localparam meas_state_t S_RST = '{done: 1'b1, default: '0};

  meas_state_t s_q;
  meas_state_t s_d;
  logic [3:0]  n;

  always_comb
  begin
    s_d       = s_q;
    n         = 4'h0;
    s_d.pulse = 1'b0;
    s_d.prev  = gen_clk;
    for (int i = 0; i < 4; i++)
    begin
      n = div_cfg[i*DIV_FIELD_W +: DIV_FIELD_W];
      if (gen_clk[i] && !s_q.prev[i])
        s_d.cnt[i] = s_q.cnt[i] + 15'h1;
      if (n == 4'h0)
        s_d.baud[i] = gen_clk[i];                        // RL12
      else
        s_d.baud[i] = s_q.cnt[i][n - 4'h1];              // RL12
    end
    s_d.bprev = s_q.baud;
    if (start)
    begin
      s_d.done  = 1'b0;                                  // RL15
      s_d.gate  = '0;
      s_d.edges = '0;
      s_d.ch    = sel[0] ? 2'd0 : sel[1] ? 2'd1 :
                  sel[2] ? 2'd2 : 2'd3;                  // RL8
    end
    else if (!s_q.done)
    begin
      if (s_q.baud[s_q.ch] && !s_q.bprev[s_q.ch]
          && s_q.edges != '1)
        s_d.edges = s_q.edges + 24'h1;
      if (s_q.gate == GATE_W'(GATE_LEN - 1))
      begin
        s_d.done  = 1'b1;                                // RL15
        s_d.value = s_q.edges;                           // RL16
        s_d.pulse = 1'b1;
      end
      else
        s_d.gate = s_q.gate + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= S_RST;
    else
      s_q <= s_d;
  end

  assign baud_src   = s_q.baud;
  assign meas_done  = s_q.done;
  assign meas_value = s_q.value;
  assign done_pulse = s_q.pulse;

endmodule // channel_clock_measure

// ==== core/clock_generator_pkg.sv ====
// constants shared by the clock generator programming front end
package clock_generator_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_POINTER  = 8'hA0;
  localparam logic [7:0] OFF_WIN_ONE  = 8'hA4;
  localparam logic [7:0] OFF_CTRL     = 8'hA8;
  localparam logic [7:0] OFF_WIN_TWO  = 8'hAC;
  localparam logic [7:0] OFF_IRQ_STAT = 8'hB0;
  localparam logic [7:0] OFF_IRQ_MASK = 8'hB4;

  // control word fields
  localparam int CTRL_PROG_BIT     = 0;
  localparam int CTRL_SEL_LO       = 1;
  localparam int CTRL_SEL_HI       = 4;
  localparam int CTRL_READBACK_BIT = 6;
  localparam int CTRL_DIV_LOAD_BIT = 7;
  localparam int CTRL_DIV_LO       = 8;
  localparam int CTRL_DIV_HI       = 23;
  localparam int DIV_FIELD_W       = 4;

  // status word fields
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_ERR_BIT   = 1;
  localparam int STAT_MEAS_BIT  = 2;
  localparam int STAT_VALUE_LO  = 8;
  localparam int VALUE_W        = 24;

  // interrupt status and mask layout
  localparam int IRQ_PROG_DONE = 0;
  localparam int IRQ_PROG_ERR  = 1;
  localparam int IRQ_MEAS_DONE = 2;
  localparam int IRQ_W         = 3;

  // image locations sent to the generators
  localparam logic [7:0] IMG_FIRST_ADDR = 8'h08;
  localparam logic [7:0] IMG_LAST_ADDR  = 8'h57;
  localparam int         IMG_ADDR_W     = 8;
  localparam int         IMG_DATA_W     = 8;

  // timing
  localparam int CLK_KHZ         = 20_000;
  localparam int SER_HALF_NS     = 2_500;
  localparam int SER_HALF_CYCLES = SER_HALF_NS * CLK_KHZ / 1_000_000;
  localparam int GATE_MS         = 100;
  localparam int GATE_CYCLES     = GATE_MS * CLK_KHZ;

  // serial programming sequencer
  typedef enum logic [1:0] {
    PG_IDLE  = 2'b00,
    PG_LOAD  = 2'b01,
    PG_SHIFT = 2'b10,
    PG_ACK   = 2'b11
  } prog_state_t;

endpackage

// ==== core/clock_generator_program_ctrl.sv ====
// register front end and serial programmer for two clock generators
//
// Notes on behaviour
// RL1 - two image memories, one per generator
// RL2 - pointer register selects image location
// RL3 - first window accesses first image
// RL4 - second window accesses second image
// RL5 - logic serially programs generators from images
// RL6 - control on write, status on read
// RL7 - control bit 0 starts programming, self-clears
// RL8 - bits 1 to 4 pick measured channel
// RL9 - bit 6 picks value or control readback
// RL10 - bit 7 loads post-dividers, else keeps
// RL11 - four-bit divider fields from bit 8
// RL12 - divider n divides clock by two^n
// RL13 - status bit 0 low while programming
// RL14 - status bit 1 flags programming error
// RL15 - status bit 2 low while measuring
// RL16 - measured value is frequency over ten
// RL17 - program command ignored while busy
//
// Chosen here: the AHB-Lite register port.
module clock_generator_program_ctrl
  import clock_generator_pkg::*;
#(
  parameter int GATE_LEN = GATE_CYCLES,
  parameter int HALF_LEN = SER_HALF_CYCLES
)(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // generator serial programming
  output logic             prog_sclk,
  output logic             prog_sdata,
  output logic             prog_sel_one_n,
  output logic             prog_sel_two_n,
  input  wire logic        prog_ack_n,
  // generator outputs
  input  wire logic        generator_output_one,
  input  wire logic        generator_output_two,
  input  wire logic        generator_output_three,
  input  wire logic        generator_output_four,
  // channel baud sources
  output logic             channel_one_baud_source,
  output logic             channel_two_baud_source,
  output logic             channel_three_baud_source,
  output logic             channel_four_baud_source,
  // interrupt
  output logic             irq
);

  localparam int DEPTH  = 1 << IMG_ADDR_W;
  localparam int TICK_W = $clog2(HALF_LEN + 1);

  if (HALF_LEN < 1)
    $error("serial half period too short");
  if (int'(IMG_LAST_ADDR) >= DEPTH)
    $error("image range exceeds depth");

  typedef struct packed {
    logic                                  hready;
    logic [31:0]                           hrdata;
    logic                                  hresp;
    logic                                  wr_pend;
    logic                                  rd_pend;
    logic [7:0]                            addr;
    logic                                  hit;
    logic [IMG_ADDR_W-1:0]                 ptr;
    logic [23:0]                           ctrl;
    logic [15:0]                           div;
    logic                                  meas_start;
    logic [3:0]                            meas_sel;
    logic [DEPTH-1:0][IMG_DATA_W-1:0]      img1;
    logic [DEPTH-1:0][IMG_DATA_W-1:0]      img2;
    prog_state_t                           pg;
    logic                                  chip;
    logic [IMG_ADDR_W-1:0]                 pg_addr;
    logic [15:0]                           shift;
    logic [3:0]                            bitc;
    logic                                  phase;
    logic [TICK_W-1:0]                     tick;
    logic                                  busy;
    logic                                  err;
    logic [IRQ_W-1:0]                      istat;
    logic [IRQ_W-1:0]                      imask;
    logic                                  irq;
    logic                                  sclk;
    logic                                  sdata;
    logic [1:0]                            sel_n;
  } state_t;

  localparam state_t S_RST = '{
    hready: 1'b1,
    sdata:  1'b1,
    sel_n:  2'b11,
    pg:     PG_IDLE,
    default: '0
  };

  state_t             s_q;
  state_t             s_d;
  logic [IRQ_W-1:0]   ev;
  logic [IRQ_W-1:0]   clr;
  logic               tick_end;
  logic               finish;
  logic [3:0]         baud;
  logic               meas_done;
  logic               meas_pulse;
  logic [VALUE_W-1:0] meas_value;

  // window index of an offset: 0 none, 1 first, 2 second
  function automatic logic [1:0] win_of(logic [7:0] a);
    if (a == OFF_WIN_ONE)
      return 2'd1;
    else if (a == OFF_WIN_TWO)
      return 2'd2;
    else
      return 2'd0;
  endfunction

  assign tick_end = (s_q.tick == TICK_W'(HALF_LEN - 1));

  always_comb
  begin
    s_d            = s_q;
    ev             = '0;
    clr            = '0;
    finish         = 1'b0;
    s_d.meas_start = 1'b0;

    // write data phase
    if (s_q.wr_pend)
    begin
      s_d.wr_pend = 1'b0;
      if (s_q.hit)
      begin
        case (s_q.addr)
          OFF_POINTER:
            s_d.ptr = hwdata[IMG_ADDR_W-1:0];                 // RL2
          OFF_CTRL:
          begin
            s_d.ctrl = {hwdata[23:1], 1'b0};                 // RL6 RL7
            if (hwdata[CTRL_DIV_LOAD_BIT])
              s_d.div = hwdata[CTRL_DIV_HI:CTRL_DIV_LO];     // RL10 RL11
            if (|hwdata[CTRL_SEL_HI:CTRL_SEL_LO])
            begin
              s_d.meas_start = 1'b1;                         // RL8
              s_d.meas_sel   = hwdata[CTRL_SEL_HI:CTRL_SEL_LO];
            end
            if (hwdata[CTRL_PROG_BIT] && !s_q.busy)          // RL17
            begin
              s_d.pg      = PG_LOAD;                         // RL5 RL7
              s_d.busy    = 1'b1;                            // RL13
              s_d.err     = 1'b0;
              s_d.chip    = 1'b0;
              s_d.pg_addr = IMG_FIRST_ADDR;
            end
          end
          OFF_IRQ_STAT:
            clr = hwdata[IRQ_W-1:0];
          OFF_IRQ_MASK:
            s_d.imask = hwdata[IRQ_W-1:0];
          default:
          begin
          end
        endcase
        if (win_of(s_q.addr) == 2'd1)
          s_d.img1[s_q.ptr] = hwdata[IMG_DATA_W-1:0];        // RL1 RL3
        else if (win_of(s_q.addr) == 2'd2)
          s_d.img2[s_q.ptr] = hwdata[IMG_DATA_W-1:0];        // RL1 RL4
      end
    end

    // read answer after one wait state
    if (s_q.rd_pend)
    begin
      s_d.rd_pend = 1'b0;
      s_d.hready  = 1'b1;
      s_d.hrdata  = 32'h0000_0000;
      if (s_q.hit)
      begin
        case (s_q.addr)
          OFF_POINTER:
            s_d.hrdata[IMG_ADDR_W-1:0] = s_q.ptr;
          OFF_CTRL:
          begin
            s_d.hrdata[STAT_DONE_BIT] = !s_q.busy;           // RL6 RL13
            s_d.hrdata[STAT_ERR_BIT]  = s_q.err;             // RL14
            s_d.hrdata[STAT_MEAS_BIT] = meas_done;           // RL15
            if (s_q.ctrl[CTRL_READBACK_BIT])
              s_d.hrdata[31:STAT_VALUE_LO] = s_q.ctrl;       // RL9
            else
              s_d.hrdata[31:STAT_VALUE_LO] = meas_value;     // RL9 RL16
          end
          OFF_IRQ_STAT:
            s_d.hrdata[IRQ_W-1:0] = s_q.istat;
          OFF_IRQ_MASK:
            s_d.hrdata[IRQ_W-1:0] = s_q.imask;
          default:
          begin
          end
        endcase
        if (win_of(s_q.addr) == 2'd1)
          s_d.hrdata[IMG_DATA_W-1:0] = s_q.img1[s_q.ptr];    // RL3
        else if (win_of(s_q.addr) == 2'd2)
          s_d.hrdata[IMG_DATA_W-1:0] = s_q.img2[s_q.ptr];    // RL4
      end
    end

    // address phase
    if (hsel && htrans[1] && hready)
    begin
      s_d.addr = haddr[7:0];
      s_d.hit  = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'b00);
      if (hwrite)
        s_d.wr_pend = 1'b1;
      else
      begin
        s_d.rd_pend = 1'b1;
        s_d.hready  = 1'b0;
      end
    end

    // serial programming sequencer
    if (s_q.pg != PG_IDLE && s_q.pg != PG_LOAD)
      s_d.tick = tick_end ? '0 : s_q.tick + 1'b1;
    unique case (s_q.pg)
      PG_IDLE:
      begin
      end
      PG_LOAD:
      begin
        s_d.shift = {s_q.pg_addr, s_q.chip ? s_q.img2[s_q.pg_addr]
                                           : s_q.img1[s_q.pg_addr]}; // RL5
        s_d.sdata = s_d.shift[15];
        s_d.sel_n = s_q.chip ? 2'b01 : 2'b10;                // RL1
        s_d.bitc  = 4'hF;
        s_d.phase = 1'b0;
        s_d.sclk  = 1'b0;
        s_d.tick  = '0;
        s_d.pg    = PG_SHIFT;
      end
      PG_SHIFT:
      begin
        if (tick_end)
        begin
          s_d.phase = !s_q.phase;
          s_d.sclk  = !s_q.phase;
          if (s_q.phase)
          begin
            if (s_q.bitc == 4'h0)
            begin
              s_d.sdata = 1'b1;
              s_d.pg    = PG_ACK;
            end
            else
            begin
              s_d.bitc  = s_q.bitc - 4'h1;
              s_d.shift = {s_q.shift[14:0], 1'b0};
              s_d.sdata = s_q.shift[14];
            end
          end
        end
      end
      PG_ACK:
      begin
        if (tick_end)
        begin
          s_d.phase = !s_q.phase;
          s_d.sclk  = !s_q.phase;
          if (s_q.phase)
          begin
            if (prog_ack_n)
            begin
              s_d.err = 1'b1;                                // RL14
              ev[IRQ_PROG_ERR] = 1'b1;
              finish = 1'b1;
            end
            else if (s_q.pg_addr == IMG_LAST_ADDR)
            begin
              if (!s_q.chip)
              begin
                s_d.chip    = 1'b1;
                s_d.pg_addr = IMG_FIRST_ADDR;
                s_d.pg      = PG_LOAD;
              end
              else
                finish = 1'b1;
            end
            else
            begin
              s_d.pg_addr = s_q.pg_addr + 1'b1;
              s_d.pg      = PG_LOAD;
            end
          end
        end
      end
    endcase
    if (finish)
    begin
      s_d.pg    = PG_IDLE;
      s_d.busy  = 1'b0;                                      // RL13
      s_d.sel_n = 2'b11;
      s_d.sclk  = 1'b0;
      s_d.sdata = 1'b1;
      ev[IRQ_PROG_DONE] = 1'b1;
    end
    ev[IRQ_MEAS_DONE] = meas_pulse;

    // sticky status, set wins over clear
    s_d.istat = (s_q.istat & ~clr) | ev;
    s_d.irq   = |(s_d.istat & s_d.imask);
    s_d.hresp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= S_RST;
    else
      s_q <= s_d;
  end

  channel_clock_measure #(
    .GATE_LEN   (GATE_LEN)
  ) u_measure (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .gen_clk    ({generator_output_four, generator_output_three,
                  generator_output_two, generator_output_one}),
    .div_cfg    (s_q.div),
    .start      (s_q.meas_start),
    .sel        (s_q.meas_sel),
    .baud_src   (baud),
    .meas_done  (meas_done),
    .meas_value (meas_value),
    .done_pulse (meas_pulse)
  );

  assign hreadyout                 = s_q.hready;
  assign hrdata                    = s_q.hrdata;
  assign hresp                     = s_q.hresp;
  assign prog_sclk                 = s_q.sclk;
  assign prog_sdata                = s_q.sdata;
  assign prog_sel_one_n            = s_q.sel_n[0];
  assign prog_sel_two_n            = s_q.sel_n[1];
  assign channel_one_baud_source   = baud[0];
  assign channel_two_baud_source   = baud[1];
  assign channel_three_baud_source = baud[2];
  assign channel_four_baud_source  = baud[3];
  assign irq                       = s_q.irq;

endmodule // clock_generator_program_ctrl

// ==== testbench/clock_generator_model.sv ====
// behavioural model of the two programmable generator chips
module clock_generator_model (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // serial link
  input  wire logic        prog_sclk,
  input  wire logic        prog_sdata,
  input  wire logic        prog_sel_one_n,
  input  wire logic        prog_sel_two_n,
  output logic             prog_ack_n,
  // scenario control and observation
  input  wire logic        nack_req,
  output logic [3:0]       gen_clk,
  output logic [15:0]      first_word,
  output logic [15:0]      last_word,
  output int               word_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] shift_q;
  logic [4:0]  bit_q;
  logic        sclk_q;
  logic        sel;
  logic [3:0]  cnt_q [4];

  // released ack line is pulled up
  assign sel = !prog_sel_one_n || !prog_sel_two_n;
  assign prog_ack_n = !(sel && bit_q == 5'd16 && !nack_req);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {shift_q, bit_q, sclk_q, gen_clk} <= '0;
      {first_word, last_word} <= '0;
      word_count <= 0;
      for (int i = 0; i < 4; i++) cnt_q[i] <= 4'h0;
    end
    else
    begin
      sclk_q <= prog_sclk;
      if (!sel)
        bit_q <= 5'd0;
      else if (prog_sclk && !sclk_q)
        shift_q <= {shift_q[14:0], prog_sdata};
      else if (!prog_sclk && sclk_q)
      begin
        bit_q <= (bit_q == 5'd16) ? 5'd0 : bit_q + 5'd1;
        if (bit_q == 5'd15)
        begin
          last_word <= shift_q;
          if (word_count == 0) first_word <= shift_q;
          word_count <= word_count + 1;
        end
      end
      // output i toggles every i+2 cycles
      for (int i = 0; i < 4; i++)
      begin
        cnt_q[i] <= (cnt_q[i] == 4'(i + 1)) ? 4'h0 : cnt_q[i] + 4'h1;
        if (cnt_q[i] == 4'(i + 1)) gen_clk[i] <= !gen_clk[i];
      end
    end
  end
endmodule // clock_generator_model

// ==== testbench/clock_generator_props.sv ====
// assertion checker for the clock generator register front end
module clock_generator_props
  import clock_generator_pkg::*;
#(
  parameter int GATE_LEN = GATE_CYCLES,
  parameter int HALF_LEN = SER_HALF_CYCLES
)(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // serial link
  input wire logic        prog_sclk,
  input wire logic        prog_sdata,
  input wire logic        prog_sel_one_n,
  input wire logic        prog_sel_two_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic hit;
  logic wr_ctrl_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  assign take = hsel && htrans[1] && hready;
  assign hit  = haddr[31:8] == 24'h0 && haddr[1:0] == 2'h0
             && haddr[7:0] >= OFF_POINTER && haddr[7:0] <= OFF_IRQ_MASK;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_ctrl_q <= 1'b0;
    else
      wr_ctrl_q <= take && hwrite && haddr == {24'h0, OFF_CTRL};
  end

  a_resp_always_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_write_zero_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write inserted a wait state");
  a_read_one_wait: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state count wrong");
  a_unmapped_reads_zero: assert property (
    take && !hwrite && !hit |=> ##1 (hreadyout && hrdata == 32'h0))
    else $error("unmapped read not zero");
  a_one_chip_selected: assert property (
    !(!prog_sel_one_n && !prog_sel_two_n))
    else $error("both generators selected");
  a_sdata_held_high: assert property (
    prog_sclk && $past(prog_sclk) |-> $stable(prog_sdata))
    else $error("serial data moved while clock high");
  a_prog_start_seen: assert property (
    wr_ctrl_q && hwdata[0] && prog_sel_one_n && prog_sel_two_n
    |-> ##[1:3] !prog_sel_one_n)
    else $error("program command did not start");
  a_no_restart_busy: assert property (
    !prog_sel_two_n |=> prog_sel_one_n)
    else $error("programming restarted while busy");
endmodule // clock_generator_props

bind clock_generator_program_ctrl clock_generator_props #(
  .GATE_LEN(GATE_LEN), .HALF_LEN(HALF_LEN)
) props_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .prog_sclk(prog_sclk), .prog_sdata(prog_sdata),
  .prog_sel_one_n(prog_sel_one_n), .prog_sel_two_n(prog_sel_two_n)
);

// ==== testbench/testbench.sv ====
// self-checking bench for the clock generator register front end
module testbench;
  import clock_generator_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GATE  = 200;
  localparam int LIMIT = 60000;
  localparam logic [3:0] DIVN [4] = '{4'd1, 4'd0, 4'd2, 4'd3};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        prog_sclk, prog_sdata, prog_sel_one_n, prog_sel_two_n;
  logic        prog_ack_n, nack_req;
  logic [3:0]  gen_clk;
  logic [15:0] first_word, last_word;
  logic [23:0] w;
  int          word_count, err_count, checks, seed, cyc;
  wire  [3:0]  baud;
  logic [3:0]  baud_p;
  int          bcnt [4];
  int          b0 [4];

  clock_generator_program_ctrl #(.GATE_LEN(GATE), .HALF_LEN(2))
  clock_generator_program_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .prog_sclk(prog_sclk), .prog_sdata(prog_sdata),
    .prog_sel_one_n(prog_sel_one_n), .prog_sel_two_n(prog_sel_two_n),
    .prog_ack_n(prog_ack_n), .generator_output_one(gen_clk[0]),
    .generator_output_two(gen_clk[1]),
    .generator_output_three(gen_clk[2]),
    .generator_output_four(gen_clk[3]),
    .channel_one_baud_source(baud[0]),
    .channel_two_baud_source(baud[1]),
    .channel_three_baud_source(baud[2]),
    .channel_four_baud_source(baud[3]),
    .irq(irq));

  clock_generator_model clock_generator_model_i (
    .hclk(hclk), .hresetn(hresetn), .prog_sclk(prog_sclk),
    .prog_sdata(prog_sdata), .prog_sel_one_n(prog_sel_one_n),
    .prog_sel_two_n(prog_sel_two_n), .prog_ack_n(prog_ack_n),
    .nack_req(nack_req), .gen_clk(gen_clk), .first_word(first_word),
    .last_word(last_word), .word_count(word_count));

  always #25 hclk = ~hclk;

  // rising edges seen on each channel baud source pin
  always @(posedge hclk)
  begin
    baud_p <= baud;
    for (int i = 0; i < 4; i++)
      if (baud[i] && !baud_p[i])
        bcnt[i] <= bcnt[i] + 1;
  end

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_count++;
      finish_test();
    end
  end

  task finish_test;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_near(input logic [23:0] got, input int exp);
    checks++;
    if ((^got === 1'bx) || got + 1 < exp || got > exp + 1)
    begin
      err_count++;
      $display("[FAIL] %0t measured %0d expected %0d", $time, got, exp);
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] v);
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    @(posedge hclk iff hreadyout);
    htrans <= 2'b00;
    hwdata <= v;
    @(posedge hclk iff hreadyout);
  endtask

  task rd(input logic [31:0] a, output logic [31:0] v);
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    @(posedge hclk iff hreadyout);
    htrans <= 2'b00;
    @(posedge hclk iff hreadyout);
    v = hrdata;
  endtask

  task rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  task poll(input int b, output logic [31:0] v);
    do rd(32'hA8, v); while (v[b] !== 1'b1);
  endtask

  function int exp_meas(input int ch, input int n);
    return GATE / ((2 * ch + 4) << n);
  endfunction

  function logic [31:0] exp_readback(input logic [23:0] cw);
    return {cw[23:1], 1'b0, 8'h05};
  endfunction

  initial
  begin
    seed = 5;
    {hclk, hresetn, hwrite, nack_req, err_count, checks, cyc} = '0;
    {haddr, hwdata, htrans} = '0;
    hsel  = 1'b1;
    hsize = 3'b010;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(32'hA8, 32'h05);
    rchk(32'hA0, 32'h0);
    rchk(32'h1A8, 32'h0);
    rchk(32'hA2, 32'h0);
    $display("test reset done");
    repeat (8)
    begin
      r = $random(seed);
      wr(32'hA0, {24'h0, r[7:0]});
      wr(32'hA4, {24'h0, r[15:8]});
      wr(32'hAC, {24'h0, r[23:16]});
      rchk(32'hA0, {24'h0, r[7:0]});
      rchk(32'hA4, {24'h0, r[15:8]});
      rchk(32'hAC, {24'h0, r[23:16]});
    end
    $display("test images done");
    r = $random(seed);
    w = {r[15:0], 8'hC0};
    wr(32'hA8, {r[31:24], w});
    rchk(32'hA8, exp_readback(w));
    $display("test readback done");
    wr(32'hA8, 32'h0032_0180);
    for (int ch = 0; ch < 4; ch++)
    begin
      wr(32'hA8, {8'h00, 16'hFFFF, 8'h02 << ch});
      rd(32'hA8, d);
      chk({31'h0, d[2]}, 32'h0);
      poll(2, d);
      chk_near(d[31:8], exp_meas(ch, int'(DIVN[ch])));
    end
    b0 = bcnt;
    repeat (GATE) @(posedge hclk);
    for (int ch = 0; ch < 4; ch++)
      chk_near(24'(bcnt[ch] - b0[ch]),
               exp_meas(ch, int'(DIVN[ch])));
    $display("test measure done");
    wr(32'hB0, 32'h7);
    wr(32'hA0, 32'h08);
    wr(32'hA4, 32'h5A);
    wr(32'hA0, 32'h57);
    wr(32'hAC, 32'hC3);
    wr(32'hA8, 32'h41);
    rd(32'hA8, d);
    chk(d & 32'h101, 32'h0);
    wr(32'hA8, 32'h41);
    poll(0, d);
    chk(d & 32'h3, 32'h1);
    chk({16'h0, first_word}, 32'h085A);
    chk({16'h0, last_word}, 32'h57C3);
    chk(32'(word_count), 32'd160);
    $display("test program done");
    wr(32'hB0, 32'h7);
    nack_req <= 1'b1;
    wr(32'hA8, 32'h01);
    poll(0, d);
    chk(d & 32'h3, 32'h3);
    rchk(32'hB0, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(32'hB4, 32'h2);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    wr(32'hB0, 32'h2);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    rchk(32'hB0, 32'h1);
    nack_req <= 1'b0;
    $display("test error done");
    finish_test();
  end
endmodule // testbench
